// ### hw/psl_regs.svh
// Offsets, bit positions, reset words and timing figures of the strap latch
// Included by the strap latch modules; definitions only
`ifndef PSL_REGS_SVH
`define PSL_REGS_SVH

// APB address width and register byte offsets
`define PSL_AW              16
`define PSL_OFF_BOOT_CFG    16'h3410
`define PSL_OFF_SWAP_CFG    16'h3414
`define PSL_OFF_RP_CFG      16'h0224
`define PSL_OFF_STRAP_STAT  16'h0400

// Field positions
`define PSL_BIT_NO_REBOOT   5
`define PSL_BIT_BOOT_DEST   3
`define PSL_BIT_TOP_SWAP    0
`define PSL_BIT_RP_SYNC     0
`define PSL_BIT_RP_SDOUT    1
`define PSL_ST_XOR          0
`define PSL_ST_XSEL_LSB     1
`define PSL_ST_SUSP         5
`define PSL_ST_CORE25       6
`define PSL_ST_PULLUP       7

// Boot region address bit that top-block swap inverts
`define PSL_SWAP_ADDR_BIT   16

// Reset values
`define PSL_RST_WORD        32'h0000_0000
`define PSL_RST_STRAPS      10'h000

// Pull-up release time and clock rate
`define PSL_PULLUP_OFF_MS   100
`define PSL_CLK_KHZ         100000
`define PSL_PU_CNT_W        24
// Cycles from a pin change to the start of the count, with margin
`define PSL_SYNC_LAG        8

`endif

// ### hw/psl_pkg.sv
// Types shared by the strap latch modules
// Assumes psl_regs.svh for numeric constants
package psl_pkg;

    // Edge-sampled strap pins, as seen at the pins or as latched
    typedef struct packed {
        logic       top_swap_n;  // Low selects top-block swap
        logic       no_reboot;   // High selects no-reboot
        logic       boot_dest;   // High routes boot ranges to LPC
        logic       xor_entry_n; // Low enters XOR chain test
        logic [3:0] xor_sel;     // XOR chain choice
        logic       sdout;       // Root port configuration bit 1
        logic       sync;        // Root port configuration bit 0
    } psl_straps_t;

    // Pull-up control of the 2.5 V regulator strap pin
    typedef enum logic [1:0] {
        PSL_PU_ON    = 2'b00,
        PSL_PU_COUNT = 2'b01,
        PSL_PU_OFF   = 2'b11
    } psl_pu_state_t;

endpackage : psl_pkg

// ### hw/psl_sync.sv
// Three-stage pin synchroniser with agreement filter
// Assumes asynchronous inputs; output settles once stages two and three agree
`timescale 1ns/1ps
`include "psl_regs.svh"

module psl_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_nxt;

    // Take a new level only where the last two stages agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            q_nxt[i] = (s2_r[i] == s3_r[i]) ? s2_r[i] : q[i];
        end
    end

    // First stage feeds the second and nothing else
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q    <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q    <= q_nxt;
        end
    end

endmodule : psl_sync

// ### hw/psl_top.sv
// Power-on strap latch: captures board straps and exposes them over APB
// Assumes asynchronous pins, one 100 MHz clock and an APB master
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "psl_regs.svh"

// How it works
// - power_ok rise samples top swap; low inverts A16 on boot region cycles.
// - Latched top swap reads in bit 0 of word 3414h.
// - Software cannot clear top swap while its strap was latched active.
// - power_ok rise samples no-reboot pin; high disables watchdog reboot.
// - Latched no-reboot reads in bit 5 of word 3410h.
// - Suspend regulator enable follows its pin continuously.
// - Reset rise samples 2.5 V strap; low enables; pull-up off by 100 ms.
// - power_ok rise samples boot destination; bit 3 of 3410h also sets it.
// - Low test entry pin at power_ok rise enters XOR test, chain chosen.
// - Without test entry, sampled serial out sets root port bit 1.
// - power_ok rise copies sampled sync pin into root port bit 0.
module psl_top
    import psl_pkg::*;
#(
    parameter int unsigned PULLUP_OFF_CYC =
        `PSL_PULLUP_OFF_MS * `PSL_CLK_KHZ
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              power_ok,
    input  wire logic              resume_well_reset,
    input  wire psl_straps_t       strap_pins,
    input  wire logic              suspend_regulator_enable_pin,
    input  wire logic              core25_regulator_strap_pin,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [`PSL_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [31:0]       fw_addr_in,
    input  wire logic              fw_hit_in,
    output logic      [31:0]       fw_addr_out,
    output logic                   no_reboot_mode,
    output logic                   boot_dest_lpc,
    output logic                   susp_vreg_en,
    output logic                   core25_vreg_en,
    output logic                   core25_pullup_en,
    output logic                   xor_test_mode,
    output logic      [3:0]        xor_chain_sel,
    output logic      [1:0]        rp_cfg
);

    // Count short by the pin filter lag so release lands inside the limit
    localparam logic [`PSL_PU_CNT_W-1:0] PU_LAST =
        `PSL_PU_CNT_W'(PULLUP_OFF_CYC - `PSL_SYNC_LAG);

    // Synchronised pins
    psl_straps_t pin_q;
    logic        pok_q;
    logic        rsm_q;
    logic        susp_q;
    logic        c25_q;

    psl_sync #(
        .W (14)
    ) u_sync (
        .mclk (mclk),
        .rstn (rstn),
        .d    ({power_ok, resume_well_reset, suspend_regulator_enable_pin,
                core25_regulator_strap_pin, strap_pins}),
        .q    ({pok_q, rsm_q, susp_q, c25_q, pin_q})
    );

    // Edge detection on the filtered sampling signals
    logic pok_prev_r;
    logic rsm_prev_r;
    logic pok_rise;
    logic rsm_rise;

    assign pok_rise = pok_q & ~pok_prev_r;
    assign rsm_rise = rsm_q & ~rsm_prev_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pok_prev_r <= 1'b0;
            rsm_prev_r <= 1'b0;
        end else begin
            pok_prev_r <= pok_q;
            rsm_prev_r <= rsm_q;
        end
    end

    // APB decode; writes land on the edge where pready is seen high
    logic access;
    logic wr_en;
    logic hit_boot;
    logic hit_swap;

    assign access   = psel & penable & ~pready;
    assign wr_en    = psel & penable & pready & pwrite;
    assign hit_boot = (paddr == `PSL_OFF_BOOT_CFG);
    assign hit_swap = (paddr == `PSL_OFF_SWAP_CFG);

    // Strap group: power_ok edge state
    psl_straps_t straps_r;
    psl_straps_t straps_nxt;
    logic        ts_bit_r;
    logic        ts_bit_nxt;
    logic        boot_dest_r;
    logic        boot_dest_nxt;
    logic        xor_mode_r;
    logic        xor_mode_nxt;
    logic [1:0]  rp_cfg_r;
    logic [1:0]  rp_cfg_nxt;

    // Edge capture beats a software write in the same cycle
    always_comb begin
        straps_nxt    = straps_r;
        ts_bit_nxt    = ts_bit_r;
        boot_dest_nxt = boot_dest_r;
        xor_mode_nxt  = xor_mode_r;
        rp_cfg_nxt    = rp_cfg_r;
        if (wr_en && hit_swap) begin
            // A latched swap strap pins the bit high
            ts_bit_nxt = pwdata[`PSL_BIT_TOP_SWAP] | ~straps_r.top_swap_n;
        end
        if (wr_en && hit_boot) begin
            boot_dest_nxt = pwdata[`PSL_BIT_BOOT_DEST];
        end
        if (pok_rise) begin
            straps_nxt    = pin_q;
            ts_bit_nxt    = ~pin_q.top_swap_n;
            boot_dest_nxt = pin_q.boot_dest;
            xor_mode_nxt  = ~pin_q.xor_entry_n;
            rp_cfg_nxt[`PSL_BIT_RP_SYNC] = pin_q.sync;
            // Serial out is a test pin while XOR entry is strapped
            if (pin_q.xor_entry_n) begin
                rp_cfg_nxt[`PSL_BIT_RP_SDOUT] = pin_q.sdout;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            straps_r    <= `PSL_RST_STRAPS;
            straps_r.top_swap_n  <= 1'b1;
            straps_r.xor_entry_n <= 1'b1;
            ts_bit_r    <= 1'b0;
            boot_dest_r <= 1'b0;
            xor_mode_r  <= 1'b0;
            rp_cfg_r    <= 2'h0;
        end else begin
            straps_r    <= straps_nxt;
            ts_bit_r    <= ts_bit_nxt;
            boot_dest_r <= boot_dest_nxt;
            xor_mode_r  <= xor_mode_nxt;
            rp_cfg_r    <= rp_cfg_nxt;
        end
    end

    // Regulator group and pull-up release timer
    psl_pu_state_t            pu_st_r;
    psl_pu_state_t            pu_st_nxt;
    logic [`PSL_PU_CNT_W-1:0] pu_cnt_r;
    logic [`PSL_PU_CNT_W-1:0] pu_cnt_nxt;
    logic                     c25_en_r;
    logic                     c25_en_nxt;
    logic                     susp_en_r;

    // Pull-up held through reset, dropped a bounded time after release
    always_comb begin
        pu_st_nxt  = pu_st_r;
        pu_cnt_nxt = pu_cnt_r;
        c25_en_nxt = c25_en_r;
        if (rsm_rise) begin
            c25_en_nxt = ~c25_q;
        end
        unique case (pu_st_r)
            PSL_PU_ON: begin
                pu_cnt_nxt = '0;
                if (rsm_rise) begin
                    pu_st_nxt = PSL_PU_COUNT;
                end
            end
            PSL_PU_COUNT: begin
                pu_cnt_nxt = pu_cnt_r + `PSL_PU_CNT_W'(1);
                if (pu_cnt_r == PU_LAST) begin
                    pu_st_nxt = PSL_PU_OFF;
                end
            end
            PSL_PU_OFF: begin
                pu_cnt_nxt = '0;
            end
            default: begin
                pu_st_nxt  = PSL_PU_ON;
                pu_cnt_nxt = '0;
            end
        endcase
        // Re-entering resume reset restores the pull-up
        if (!rsm_q) begin
            pu_st_nxt  = PSL_PU_ON;
            pu_cnt_nxt = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pu_st_r   <= PSL_PU_ON;
            pu_cnt_r  <= '0;
            c25_en_r  <= 1'b0;
            susp_en_r <= 1'b0;
        end else begin
            pu_st_r   <= pu_st_nxt;
            pu_cnt_r  <= pu_cnt_nxt;
            c25_en_r  <= c25_en_nxt;
            susp_en_r <= susp_q;
        end
    end

    // APB answer group: one wait state, read data registered
    logic [31:0] rdata;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pslverr_r;
    logic        pslverr_nxt;

    always_comb begin
        rdata       = `PSL_RST_WORD;
        pslverr_nxt = 1'b0;
        unique case (paddr)
            `PSL_OFF_BOOT_CFG: begin
                rdata[`PSL_BIT_NO_REBOOT] = straps_r.no_reboot;
                rdata[`PSL_BIT_BOOT_DEST] = boot_dest_r;
            end
            `PSL_OFF_SWAP_CFG: begin
                rdata[`PSL_BIT_TOP_SWAP] = ts_bit_r;
            end
            `PSL_OFF_RP_CFG: begin
                rdata[1:0] = rp_cfg_r;
            end
            `PSL_OFF_STRAP_STAT: begin
                rdata[`PSL_ST_XOR]    = xor_mode_r;
                rdata[`PSL_ST_XSEL_LSB +: 4] = straps_r.xor_sel;
                rdata[`PSL_ST_SUSP]   = susp_en_r;
                rdata[`PSL_ST_CORE25] = c25_en_r;
                rdata[`PSL_ST_PULLUP] = (pu_st_r != PSL_PU_OFF);
            end
            default: begin
                pslverr_nxt = 1'b1;
            end
        endcase
        prdata_nxt = (access && !pwrite) ? rdata : `PSL_RST_WORD;
        if (!access) begin
            pslverr_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            prdata_r  <= `PSL_RST_WORD;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= prdata_nxt;
            pready_r  <= access;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Boot region address path; swap flips one address bit
    logic [31:0] fw_addr_r;
    logic [31:0] fw_addr_nxt;

    always_comb begin
        fw_addr_nxt = fw_addr_in;
        if (fw_hit_in && ts_bit_r) begin
            fw_addr_nxt[`PSL_SWAP_ADDR_BIT] = ~fw_addr_in[`PSL_SWAP_ADDR_BIT];
        end
    end

    // Output flops, including strap-only copies so every pin is registered
    logic no_reboot_r;
    logic pullup_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fw_addr_r   <= `PSL_RST_WORD;
            no_reboot_r <= 1'b0;
            pullup_r    <= 1'b1;
        end else begin
            fw_addr_r   <= fw_addr_nxt;
            no_reboot_r <= straps_nxt.no_reboot;
            pullup_r    <= (pu_st_nxt != PSL_PU_OFF);
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign fw_addr_out      = fw_addr_r;
    assign no_reboot_mode   = no_reboot_r;
    assign boot_dest_lpc    = boot_dest_r;
    assign susp_vreg_en     = susp_en_r;
    assign core25_vreg_en   = c25_en_r;
    assign core25_pullup_en = pullup_r;
    assign xor_test_mode    = xor_mode_r;
    assign xor_chain_sel    = straps_r.xor_sel;
    assign rp_cfg           = rp_cfg_r;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_swap_capture: assert property (
        pok_rise |=> ts_bit_r == !$past(pin_q.top_swap_n))
        else $error("top swap not captured at power_ok rise");

    a_swap_addr_flip: assert property (
        fw_hit_in && ts_bit_r && !pok_rise && !wr_en |=>
        fw_addr_out[16] != $past(fw_addr_in[16]))
        else $error("boot region address bit not inverted");

    a_swap_read_back: assert property (
        access && !pwrite && hit_swap |=> prdata[0] == $past(ts_bit_r))
        else $error("top swap read back wrong");

    a_swap_no_clear: assert property (
        !straps_r.top_swap_n && !pok_rise |=> ts_bit_r)
        else $error("top swap cleared while strap active");

    a_noreboot_follow: assert property (
        pok_rise |=> ##1 no_reboot_mode == $past(pin_q.no_reboot, 2))
        else $error("no-reboot mode not taken from strap");

    a_noreboot_read: assert property (
        access && !pwrite && hit_boot |=>
        prdata[5] == $past(straps_r.no_reboot))
        else $error("no-reboot bit read back wrong");

    a_susp_track: assert property (
        suspend_regulator_enable_pin [*6] |-> susp_vreg_en)
        else $error("suspend regulator not enabled by pin");

    a_core25_sample: assert property (
        rsm_rise |=> core25_vreg_en == !$past(c25_q))
        else $error("2.5 V regulator enable not sampled");

    a_pullup_release: assert property (
        pu_st_r == PSL_PU_COUNT && pu_cnt_r == PU_LAST && rsm_q |=>
        ##1 !core25_pullup_en)
        else $error("pull-up not released in time");

    a_boot_dest: assert property (
        pok_rise |=> boot_dest_lpc == $past(pin_q.boot_dest))
        else $error("boot destination not captured");

    a_xor_entry: assert property (
        pok_rise && !pin_q.xor_entry_n |=>
        xor_test_mode && xor_chain_sel == $past(pin_q.xor_sel))
        else $error("XOR chain test not entered");

    a_rp_bits: assert property (
        pok_rise && pin_q.xor_entry_n |=>
        rp_cfg == $past({pin_q.sdout, pin_q.sync}))
        else $error("root port bits not captured");

    a_rp_sync: assert property (
        pok_rise |=> rp_cfg[0] == $past(pin_q.sync))
        else $error("root port bit 0 not captured");

    a_strap_hold: assert property (
        !pok_rise |=> $stable(straps_r) && $stable(xor_test_mode))
        else $error("strap changed outside power_ok rise");

endmodule : psl_top

// ### test/psl_board.sv
// Board model: strap resistors and supply sequencing at the latch pins
// Assumes the bench sets wanted levels; pins change just after mclk rises
`timescale 1ns/1ps

module psl_board
    import psl_pkg::*;
(
    input  wire logic        mclk,
    input  wire psl_straps_t strap_set,
    input  wire logic        xor_wanted,
    input  wire logic        pwr_good,
    input  wire logic        rsm_done,
    input  wire logic        susp_set,
    input  wire logic        c25_set,
    output psl_straps_t      strap_pins,
    output logic             power_ok,
    output logic             resume_well_reset,
    output logic             susp_pin,
    output logic             c25_pin
);
    // Test entry stays on its pull-up unless XOR testing is wanted
    always_ff @(posedge mclk) begin
        strap_pins             <= strap_set;
        strap_pins.xor_entry_n <= !xor_wanted;
        power_ok               <= pwr_good;
        resume_well_reset      <= rsm_done;
        susp_pin               <= susp_set;
        c25_pin                <= c25_set;
    end
endmodule : psl_board

// ### test/psl_top_tb_top.sv
// Self-checking bench for the strap latch: APB reads plus pin sequences
// Assumes psl_top, psl_board and a short pull-up release count
`timescale 1ns/1ps
`include "psl_regs.svh"

module psl_top_tb_top;
    import psl_pkg::*;
    localparam int unsigned PU_CYC = 20;
    logic        mclk, rstn, psel, penable, pwrite, fw_hit_in;
    logic        xor_wanted, pwr_good, rsm_done, susp_pin, c25_pin;
    logic        susp_set, c25_set;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, fw_addr_in, fw_addr_out, rd;
    logic        pready, pslverr, no_reboot_mode, boot_dest_lpc;
    logic        susp_vreg_en, core25_vreg_en, core25_pullup_en;
    logic        xor_test_mode, power_ok, resume_well_reset, err;
    logic [3:0]  xor_chain_sel;
    logic [1:0]  rp_cfg;
    psl_straps_t strap_set, strap_pins;
    int          failures, samples_checked;

    psl_top #(.PULLUP_OFF_CYC(PU_CYC)) u_psl_top (
        .mclk(mclk), .rstn(rstn), .power_ok(power_ok),
        .resume_well_reset(resume_well_reset), .strap_pins(strap_pins),
        .suspend_regulator_enable_pin(susp_pin),
        .core25_regulator_strap_pin(c25_pin),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fw_addr_in(fw_addr_in), .fw_hit_in(fw_hit_in),
        .fw_addr_out(fw_addr_out), .no_reboot_mode(no_reboot_mode),
        .boot_dest_lpc(boot_dest_lpc), .susp_vreg_en(susp_vreg_en),
        .core25_vreg_en(core25_vreg_en),
        .core25_pullup_en(core25_pullup_en),
        .xor_test_mode(xor_test_mode), .xor_chain_sel(xor_chain_sel),
        .rp_cfg(rp_cfg));

    psl_board u_psl_board (
        .mclk(mclk), .strap_set(strap_set), .xor_wanted(xor_wanted),
        .pwr_good(pwr_good), .rsm_done(rsm_done), .susp_set(susp_set),
        .c25_set(c25_set), .strap_pins(strap_pins),
        .power_ok(power_ok), .resume_well_reset(resume_well_reset),
        .susp_pin(susp_pin), .c25_pin(c25_pin));

    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // One APB transfer; waits on pready, only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] wd);
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk("prdata", rd, e);
    endtask : rd_chk

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    task automatic fw_chk(input logic [31:0] a, input logic h,
                          input logic [31:0] e);
        @(posedge mclk);
        fw_addr_in <= a;
        fw_hit_in  <= h;
        settle(1);
        chk("fw_addr_out", fw_addr_out, e);
    endtask : fw_chk

    // Watchdog: the whole run needs well under 2000 cycles
    initial begin
        #50us;
        failures++;
        conclude();
    end

    // Main sequence
    initial begin
        failures = 0;
        samples_checked = 0;
        {rstn, psel, penable, pwrite, fw_hit_in, xor_wanted} = '0;
        {pwr_good, rsm_done, susp_set, c25_set} = '0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        fw_addr_in = 32'h0000_0000;
        strap_set = '{1'b0, 1'b1, 1'b1, 1'b1, 4'h5, 1'b1, 1'b1};
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        settle(1);
        chk("pullup", 32'(core25_pullup_en), 32'h1);
        chk("no_reboot", 32'(no_reboot_mode), 32'h0);
        rd_chk(`PSL_OFF_BOOT_CFG, 32'h0000_0000);
        rd_chk(`PSL_OFF_SWAP_CFG, 32'h0000_0000);
        rd_chk(`PSL_OFF_RP_CFG, 32'h0000_0000);
        apb(1'b0, 16'h0100, 32'h0000_0000);
        chk("pslverr", 32'(err), 32'h1);
        // Suspend regulator follows its pin at any time
        susp_set <= 1'b1;
        settle(10);
        chk("susp_vreg", 32'(susp_vreg_en), 32'h1);
        susp_set <= 1'b0;
        settle(10);
        chk("susp_vreg", 32'(susp_vreg_en), 32'h0);
        // Resume reset rises with the 2.5 V strap low
        rsm_done <= 1'b1;
        settle(10);
        chk("c25_vreg", 32'(core25_vreg_en), 32'h1);
        chk("pullup", 32'(core25_pullup_en), 32'h1);
        // Release must land within PU_CYC cycles of the pin change
        settle(PU_CYC - 10);
        chk("pullup", 32'(core25_pullup_en), 32'h0);
        rd_chk(`PSL_OFF_STRAP_STAT, 32'h0000_0040);
        // First power-good rise, top swap strapped active
        pwr_good <= 1'b1;
        settle(12);
        chk("no_reboot", 32'(no_reboot_mode), 32'h1);
        chk("boot_lpc", 32'(boot_dest_lpc), 32'h1);
        chk("xor_mode", 32'(xor_test_mode), 32'h0);
        chk("rp_cfg", 32'(rp_cfg), 32'h3);
        rd_chk(`PSL_OFF_BOOT_CFG, 32'h0000_0028);
        rd_chk(`PSL_OFF_SWAP_CFG, 32'h0000_0001);
        rd_chk(`PSL_OFF_RP_CFG, 32'h0000_0003);
        fw_chk(32'h000F_1234, 1'b1, 32'h000E_1234);
        fw_chk(32'h000F_1234, 1'b0, 32'h000F_1234);
        apb(1'b1, `PSL_OFF_SWAP_CFG, 32'h0000_0000);
        rd_chk(`PSL_OFF_SWAP_CFG, 32'h0000_0001);
        apb(1'b1, `PSL_OFF_BOOT_CFG, 32'h0000_0000);
        rd_chk(`PSL_OFF_BOOT_CFG, 32'h0000_0020);
        chk("boot_lpc", 32'(boot_dest_lpc), 32'h0);
        apb(1'b1, `PSL_OFF_BOOT_CFG, 32'h0000_0008);
        rd_chk(`PSL_OFF_BOOT_CFG, 32'h0000_0028);
        // Pins move without a power-good edge: latches must hold
        strap_set <= '{1'b1, 1'b0, 1'b0, 1'b1, 4'hA, 1'b0, 1'b0};
        xor_wanted <= 1'b1;
        settle(12);
        chk("no_reboot", 32'(no_reboot_mode), 32'h1);
        chk("rp_cfg", 32'(rp_cfg), 32'h3);
        chk("xor_mode", 32'(xor_test_mode), 32'h0);
        // Second power-good rise with XOR test entry strapped
        pwr_good <= 1'b0;
        settle(10);
        pwr_good <= 1'b1;
        settle(12);
        chk("xor_mode", 32'(xor_test_mode), 32'h1);
        chk("xor_sel", 32'(xor_chain_sel), 32'hA);
        chk("rp_cfg", 32'(rp_cfg), 32'h2);
        chk("no_reboot", 32'(no_reboot_mode), 32'h0);
        chk("boot_lpc", 32'(boot_dest_lpc), 32'h0);
        rd_chk(`PSL_OFF_SWAP_CFG, 32'h0000_0000);
        rd_chk(`PSL_OFF_STRAP_STAT, 32'h0000_0055);
        apb(1'b1, `PSL_OFF_SWAP_CFG, 32'h0000_0001);
        rd_chk(`PSL_OFF_SWAP_CFG, 32'h0000_0001);
        fw_chk(32'h0001_0010, 1'b1, 32'h0000_0010);
        apb(1'b1, `PSL_OFF_SWAP_CFG, 32'h0000_0000);
        rd_chk(`PSL_OFF_SWAP_CFG, 32'h0000_0000);
        fw_chk(32'h0001_0010, 1'b1, 32'h0001_0010);
        // Resume reset again, strap high this time
        rsm_done <= 1'b0;
        c25_set  <= 1'b1;
        settle(10);
        chk("pullup", 32'(core25_pullup_en), 32'h1);
        rsm_done <= 1'b1;
        settle(10);
        chk("c25_vreg", 32'(core25_vreg_en), 32'h0);
        conclude();
    end
endmodule : psl_top_tb_top
